// *** tdl_display.v ***
// Behaviour
// - Seven segment outputs shared by both digits
// - Select bit high lights low-order digit
// - Segments change together with the select
// - Each digit lit 5 ms, alternating
// - New value taken only at digit swap
// - Switch input is active low
// - Poll switch every 20 ms while waiting
// - Confirm low after 20 ms, then release
//
// Two-digit multiplexed seven-segment driver with a debounced button.
// Assumes segment outputs are active high, one hex nibble per digit.
`timescale 1ns/10ps
`include "tdl_regs.vh"

module tdl_display #(
    parameter SWAP_CYCLES = `TDL_SWAP_CYCLES,
    parameter POLL_CYCLES = `TDL_POLL_CYCLES
) (
    input  wire       ref_clk,
    input  wire       rst,
    input  wire [7:0] value_in,
    input  wire       value_load,
    input  wire       wait_req,
    input  wire       switch_input_n,
    output reg  [6:0] segment_outputs,
    output reg        digit_select,
    output reg        wait_busy,
    output reg        switch_closed
);

    localparam ST_IDLE    = 2'd0;
    localparam ST_POLL    = 2'd1;
    localparam ST_CONFIRM = 2'd2;

    reg  [7:0]  pending;
    reg         pending_valid;
    reg  [7:0]  shown;
    reg  [31:0] swap_count;
    reg  [31:0] poll_count;
    reg  [1:0]  state;
    reg         sw_meta;
    reg         sw_sync;
    wire        swap_tick = (swap_count == SWAP_CYCLES - 1);
    wire        poll_tick = (poll_count == POLL_CYCLES - 1);
    // Counters are 32 bits wide to hold the default poll count
    reg  [7:0]  next_shown;
    reg         next_select;
    reg  [3:0]  next_nibble;
    reg  [6:0]  next_segments;
    reg  [31:0] next_swap_count;
    reg  [1:0]  next_state;
    reg  [31:0] next_poll_count;
    reg         next_wait_busy;
    reg         next_switch_closed;

    function [6:0] seg_of;
        input [3:0] n;
        begin
            case (n)
                4'h0: seg_of = 7'h3f;
                4'h1: seg_of = 7'h06;
                4'h2: seg_of = 7'h5b;
                4'h3: seg_of = 7'h4f;
                4'h4: seg_of = 7'h66;
                4'h5: seg_of = 7'h6d;
                4'h6: seg_of = 7'h7d;
                4'h7: seg_of = 7'h07;
                4'h8: seg_of = 7'h7f;
                4'h9: seg_of = 7'h6f;
                4'ha: seg_of = 7'h77;
                4'hb: seg_of = 7'h7c;
                4'hc: seg_of = 7'h39;
                4'hd: seg_of = 7'h5e;
                4'he: seg_of = 7'h79;
                default: seg_of = 7'h71;
            endcase
        end
    endfunction

    // Pattern for the digit about to be lit, so select and segments move in one edge
    always @*
    begin
        next_shown  = pending_valid ? pending : shown;
        next_select = ~digit_select;
        if (next_select == `TDL_SEL_LOW)
            next_nibble = next_shown[3:0];
        else
            next_nibble = next_shown[7:4];
        next_segments = seg_of(next_nibble);
        if (swap_tick)
            next_swap_count = 32'h0;
        else
            next_swap_count = swap_count + 32'h1;
    end

    // Client loads whenever it likes; held until the next swap
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            pending       <= `TDL_BLANK_VALUE;
            pending_valid <= 1'b0;
        end
        else if (value_load)
        begin
            pending       <= value_in;
            pending_valid <= 1'b1;
        end
        else if (swap_tick)
            pending_valid <= 1'b0;
    end

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            swap_count      <= 32'h0;
            shown           <= `TDL_BLANK_VALUE;
            digit_select    <= `TDL_SEL_LOW;
            segment_outputs <= `TDL_SEG_OFF;
        end
        else
        begin
            // Counter free-runs from reset release; a load never restarts it
            swap_count <= next_swap_count;
            if (swap_tick)
            begin
                shown           <= next_shown;
                digit_select    <= next_select;
                segment_outputs <= next_segments;
            end
        end
    end

    // Button is asynchronous; two flops before use
    // Both flops reset to the released level, so no false press after reset
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            sw_meta <= 1'b1;
            sw_sync <= 1'b1;
        end
        else
        begin
            sw_meta <= switch_input_n;
            sw_sync <= sw_meta;
        end
    end

    // Wait-for-switch sequencer; one counter serves both the poll and the confirm wait
    always @*
    begin
        next_state         = state;
        next_poll_count    = poll_count;
        next_wait_busy     = wait_busy;
        next_switch_closed = 1'b0;
        case (state)
            ST_IDLE:
            begin
                next_poll_count = 32'h0;
                if (wait_req)
                begin
                    next_state     = ST_POLL;
                    next_wait_busy = 1'b1;
                end
            end
            ST_POLL:
            begin
                if (poll_tick)
                begin
                    next_poll_count = 32'h0;
                    if (!sw_sync)
                        next_state = ST_CONFIRM;
                end
                else
                    next_poll_count = poll_count + 32'h1;
            end
            ST_CONFIRM:
            begin
                if (poll_tick)
                begin
                    next_poll_count = 32'h0;
                    if (!sw_sync)
                    begin
                        next_state         = ST_IDLE;
                        next_wait_busy     = 1'b0;
                        next_switch_closed = 1'b1;
                    end
                    else
                        next_state = ST_POLL;
                end
                else
                    next_poll_count = poll_count + 32'h1;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            state         <= ST_IDLE;
            poll_count    <= 32'h0;
            wait_busy     <= 1'b0;
            switch_closed <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            poll_count    <= next_poll_count;
            wait_busy     <= next_wait_busy;
            switch_closed <= next_switch_closed;
        end
    end

endmodule // tdl_display

// *** tdl_display_assertions.sv ***
// Port checks for tdl_display.
// Assumes one clock and a synchronous reset.
`timescale 1ns/10ps
module tdl_chk #(parameter SWAP_CYCLES = 20, POLL_CYCLES = 50) (
    input wire       ref_clk,
    input wire       rst,
    input wire       wait_req,
    input wire       switch_input_n,
    input wire [6:0] segment_outputs,
    input wire       digit_select,
    input wire       wait_busy,
    input wire       switch_closed
);
    integer hold, busy_n, hi_n;
    reg     armed;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // First stretch skipped: its count includes reset cycles
    always @(posedge ref_clk)
    begin
        hold   <= (rst || $changed(digit_select)) ? 1 : hold + 1;
        armed  <= !rst && (armed || $changed(digit_select));
        busy_n <= wait_busy ? busy_n + 1 : 0;
        hi_n   <= switch_input_n ? hi_n + 1 : 0;
    end
    AST_RST: assert property ($fell(rst) |-> digit_select && !segment_outputs) else $error("rst");
    AST_SEG: assert property ($changed(segment_outputs) |-> $changed(digit_select)) else $error("seg");
    AST_SWAP: assert property (armed && $changed(digit_select) |-> hold == SWAP_CYCLES) else $error("swap");
    AST_HOLD: assert property (armed |-> hold <= SWAP_CYCLES) else $error("hold");
    AST_WAIT: assert property (!wait_busy && wait_req && !switch_closed |=> wait_busy) else $error("wait");
    AST_FREE: assert property ($fell(wait_busy) |-> switch_closed) else $error("free");
    AST_DEB: assert property (switch_closed |-> busy_n >= 2 * POLL_CYCLES) else $error("deb");
    AST_LOW: assert property (switch_closed |-> hi_n < 8) else $error("low");
    cover property (armed && $changed(digit_select));
    cover property (switch_closed);
    cover property (wait_busy && $rose(switch_input_n));
endmodule // tdl_chk
bind tdl_display tdl_chk #(.SWAP_CYCLES(SWAP_CYCLES), .POLL_CYCLES(POLL_CYCLES)) chk (.ref_clk, .rst,
    .wait_req, .switch_input_n, .segment_outputs, .digit_select, .wait_busy, .switch_closed);

// *** tdl_display_test.sv ***
// Bench for tdl_display with short swap and poll counts.
// Drives inputs on rising edges, samples on falling edges.
`timescale 1ns/10ps
module tdl_display_test;
    reg        ref_clk = 1'b0, rst = 1'b1, value_load = 1'b0, wait_req = 1'b0, press = 1'b0;
    reg  [7:0] value_in = 8'h18;
    wire [6:0] segment_outputs, lit_lo;
    wire       digit_select, wait_busy, switch_closed, switch_input_n;
    integer    miscompares = 0, compares = 0, n;
    always #5 ref_clk = ~ref_clk;
    tdl_display #(.SWAP_CYCLES(20), .POLL_CYCLES(50)) uut (.ref_clk, .rst, .value_in, .value_load, .wait_req,
        .switch_input_n, .segment_outputs, .digit_select, .wait_busy, .switch_closed);
    tdl_led_model led (.ref_clk, .segment_outputs, .digit_select, .press, .switch_input_n, .lit_lo);
    task complete_run;
    begin
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    task chk(input [7:0] seen, exp);
    begin
        compares = compares + 1;
        miscompares = miscompares + (seen !== exp);
        if (seen !== exp)
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
    endtask
    // Select level s, or a close pulse for s 2 or 3; only s 3 may run out
    task wt(input integer s, lim);
    begin
        for (n = 0; n < lim && (s < 2 ? digit_select !== s[0] : switch_closed !== 1'b1); n = n + 1)
            @(negedge ref_clk);
        if (n == lim && s < 3)
        begin
            miscompares = miscompares + 1;
            complete_run;
        end
    end
    endtask
    task test_display;
    begin
        chk(digit_select, 8'h01);
        wt(0, 40);
        chk(segment_outputs, 8'h3f);
        @(posedge ref_clk);
        value_load <= 1'b1;
        @(posedge ref_clk);
        value_load <= 1'b0;
        value_in <= 8'h00;
        wt(1, 40);
        chk(segment_outputs, 8'h7f);
        wt(0, 40);
        chk(lit_lo, 8'h7f);
        chk(segment_outputs, 8'h06);
        $display("display test done");
    end
    endtask
    task test_switch(input bounce);
    begin
        @(posedge ref_clk);
        press <= 1'b1;
        wait_req <= 1'b1;
        @(posedge ref_clk);
        wait_req <= 1'b0;
        if (bounce)
        begin
            repeat (60) @(posedge ref_clk);
            press <= 1'b0;
            wt(3, 100);
            chk(wait_busy, 8'h01);
            @(posedge ref_clk);
            press <= 1'b1;
        end
        wt(2, 300);
        chk(wait_busy, 8'h00);
        @(posedge ref_clk);
        press <= 1'b0;
        $display("switch test done");
    end
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        test_display;
        test_switch(1'b0);
        test_switch(1'b1);
        complete_run;
    end
endmodule // tdl_display_test

// *** tdl_led_model.sv ***
// Low digit latch and a pushbutton with pull-up.
// Assumes active-high segments, select high for the low digit.
`timescale 1ns/10ps
module tdl_led_model (
    input  wire       ref_clk,
    input  wire [6:0] segment_outputs,
    input  wire       digit_select,
    input  wire       press,
    output wire       switch_input_n,
    output reg  [6:0] lit_lo
);
    assign switch_input_n = !press;
    always @(posedge ref_clk)
        if (digit_select)
            lit_lo <= segment_outputs;
endmodule // tdl_led_model

// *** tdl_regs.vh ***
// Timing constants and reset values for the two-digit LED controller.
// Assumes a 100 MHz system clock; times are in microseconds.
`ifndef TDL_REGS_VH
`define TDL_REGS_VH
`define TDL_CLK_MHZ        100
`define TDL_SWAP_US        5000
`define TDL_SWAP_CYCLES    (`TDL_SWAP_US * `TDL_CLK_MHZ)
`define TDL_POLL_US        20000
`define TDL_POLL_CYCLES    (`TDL_POLL_US * `TDL_CLK_MHZ)
`define TDL_SEL_LOW        1'b1
`define TDL_SEL_HIGH       1'b0
`define TDL_BLANK_VALUE    8'h00
`define TDL_SEG_OFF        7'h00
`endif
